// file: external_memory_bus_16bit.sv
// 16-bit multiplexed external memory bus controller with AXI4-Lite registers
// Summary of operation
// - Any external fetch or table access switches pins to bus, even when disabled.
// - Setting bus disable from external code waits until execution is internal.
// - Idle internal execution with bus enabled: bus floats, strobes high, latch low.
// - AD15..0 carry address then data, A19..16 address only, eight control pins.
// - Only 16-bit operation exists; no software control chooses another width.
// - Address latch strobe marks address bits 15..0 valid on the bus.
// - Output enable after latch phase reads both bytes as one word.
// - Chip enable low during every access, held high throughout sleep.
// - Byte write: latch byte on both halves, high or low strobe by pointer LSB.
// - Word write even: store byte in holding latch, float data, no strobe.
// - Word write odd: latch byte high, held byte low on the bus.
// - Word write: only high strobe, byte address mirrors LSB, both byte enables on.
// - Byte select: latch byte on both halves, only the high strobe used.
// - Byte select: byte address and byte enables follow pointer LSB.
// - Write mode 1x word write, 01 byte select, 00 byte write.
// - Internal-only execution: disable bit 0 keeps bus, 1 gives pins to ports.
// - Microprocessor mode keeps the bus permanently active on the pins.
`timescale 1ns/1ps
module external_memory_bus_16bit
	import ext_mem_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic [1:0]  mem_mode_i,
	input  wire logic        exec_external_i,
	input  wire logic        sleep_i,
	input  wire logic        fetch_valid_i,
	input  wire logic [19:0] fetch_addr_i,
	output logic             fetch_ready_o,
	output logic [15:0]      fetch_data_o,
	output logic             fetch_done_o,
	input  wire logic [15:0] ad_i,
	output logic [15:0]      ad_o,
	output logic [15:0]      ad_oe_o,
	output logic [3:0]       addr_hi_o,
	output logic [3:0]       addr_hi_oe_o,
	output logic             ale_o,
	output logic             oe_n_o,
	output logic             write_strobe_high_n_o,
	output logic             write_strobe_low_n_o,
	output logic             byte_addr_lsb_o,
	output logic             ce_n_o,
	output logic             lower_byte_enable_n_o,
	output logic             upper_byte_enable_n_o,
	output logic             ctrl_oe_o,
	output logic             port_mode_o
);

	mem_mode_t   mode;
	logic [7:0]  memory_config_reg;
	logic [20:0] table_pointer_reg;
	logic [7:0]  table_latch_reg;
	logic        tbl_wr_pend_reg;
	logic        tbl_rd_pend_reg;
	logic [15:0] tbl_rdata_reg;
	logic        external_bus_disable_eff_reg;
	logic [7:0]  hold_latch_reg;

	logic        aw_full_reg;
	logic        w_full_reg;
	logic [4:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        do_write;

	logic        eng_busy;
	logic        eng_addr;
	logic        eng_data;
	logic        eng_sample;
	logic        eng_done;
	logic        access_ok;
	logic        start_tbl;
	logic        start_fetch;
	logic        start_any;
	logic        bus_active;

	logic        cur_write_reg;
	logic        cur_table_reg;
	logic [19:0] cur_addr_reg;
	logic        cur_lsb_reg;
	logic [15:0] cur_data_reg;
	logic        cur_drive_reg;
	logic        cur_wrh_reg;
	logic        cur_wrl_reg;
	logic        cur_ub_n_reg;
	logic        cur_lb_n_reg;

	logic [15:0] ad_sync1_reg;
	logic [15:0] ad_sync2_reg;

	// only the 16-bit path is built; width is fixed by configuration, not software
	assign mode = mem_mode_t'(mem_mode_i);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
	                                            input logic [31:0] new_v,
	                                            input logic [3:0]  strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// write address and data may arrive in either order; each is held until both are in
	assign s_axi_awready_o = !aw_full_reg && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_full_reg && !s_axi_bvalid_o;
	assign do_write        = aw_full_reg && w_full_reg && !s_axi_bvalid_o;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			aw_full_reg    <= 1'b0;
			w_full_reg     <= 1'b0;
			aw_addr_reg    <= 5'h00;
			w_data_reg     <= 32'h00000000;
			w_strb_reg     <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i[REG_ADDR_W-1:0];
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_i;
				w_strb_reg <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_full_reg    <= 1'b0;
				w_full_reg     <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				case (aw_addr_reg)
					CFG_OFFSET, PTR_OFFSET, LATCH_OFFSET, CMD_OFFSET: s_axi_bresp_o <= RESP_OKAY;
					default: s_axi_bresp_o <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// software registers and table command flags
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			memory_config_reg <= CFG_RESET;
			table_pointer_reg <= PTR_RESET;
			table_latch_reg   <= LATCH_RESET;
			tbl_wr_pend_reg   <= 1'b0;
			tbl_rd_pend_reg   <= 1'b0;
		end else begin
			if (start_tbl) begin
				tbl_wr_pend_reg <= 1'b0;
				tbl_rd_pend_reg <= 1'b0;
			end
			if (do_write) begin
				case (aw_addr_reg)
					CFG_OFFSET: begin
						// writes are not permitted while the bus is absent
						if (mode != MODE_MICROCONTROLLER) begin
							memory_config_reg <= 8'(merge_bytes({24'h000000, memory_config_reg},
							                     w_data_reg, w_strb_reg))
							                     & CFG_IMPL_MASK;
						end
					end
					PTR_OFFSET: begin
						table_pointer_reg <= 21'(merge_bytes({11'h000, table_pointer_reg},
						                                 w_data_reg, w_strb_reg));
					end
					LATCH_OFFSET: begin
						table_latch_reg <= 8'(merge_bytes({24'h000000, table_latch_reg},
						                               w_data_reg, w_strb_reg));
					end
					CMD_OFFSET: begin
						// a command while one is pending or running is dropped
						if (w_strb_reg[0] && !tbl_wr_pend_reg && !tbl_rd_pend_reg && !eng_busy) begin
							tbl_wr_pend_reg <= w_data_reg[CMD_WRITE_BIT];
							tbl_rd_pend_reg <= w_data_reg[CMD_READ_BIT] && !w_data_reg[CMD_WRITE_BIT];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h00000000;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= RESP_OKAY;
			s_axi_rdata_o  <= 32'h00000000;
			case (s_axi_araddr_i[REG_ADDR_W-1:0])
				CFG_OFFSET: begin
					if (mode != MODE_MICROCONTROLLER) begin
						s_axi_rdata_o[7:0] <= memory_config_reg;
					end
				end
				PTR_OFFSET:   s_axi_rdata_o[20:0] <= table_pointer_reg;
				LATCH_OFFSET: s_axi_rdata_o[7:0]  <= table_latch_reg;
				CMD_OFFSET:   s_axi_rdata_o[1:0]  <= {tbl_rd_pend_reg, tbl_wr_pend_reg};
				STAT_OFFSET: begin
					s_axi_rdata_o[STAT_BUSY_BIT]  <= eng_busy;
					s_axi_rdata_o[STAT_EXT_BIT]   <= bus_active;
					s_axi_rdata_o[STAT_EXTERNAL_BUS_DISABLE_BIT] <= external_bus_disable_eff_reg;
					s_axi_rdata_o[STAT_PEND_BIT]  <= tbl_wr_pend_reg || tbl_rd_pend_reg;
					s_axi_rdata_o[STAT_DATA_LSB +: 16] <= tbl_rdata_reg;
				end
				default: s_axi_rresp_o <= RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	assign s_axi_arready_o = !s_axi_rvalid_o;

	// no access is started in sleep or when the bus does not exist
	assign access_ok   = !eng_busy && !sleep_i && (mode != MODE_MICROCONTROLLER);
	assign start_tbl   = access_ok && (tbl_wr_pend_reg || tbl_rd_pend_reg);
	assign start_fetch = access_ok && !tbl_wr_pend_reg && !tbl_rd_pend_reg && fetch_valid_i;
	assign start_any   = start_tbl || start_fetch;
	assign fetch_ready_o = start_fetch;

	// the disable bit takes effect only once execution is internal
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			external_bus_disable_eff_reg <= 1'b0;
		end else if (!exec_external_i) begin
			external_bus_disable_eff_reg <= memory_config_reg[CFG_EXTERNAL_BUS_DISABLE_BIT];
		end
	end

	always_comb begin
		case (mode)
			MODE_MICROPROCESSOR:  bus_active = 1'b1;
			MODE_MICROCONTROLLER: bus_active = 1'b0;
			// an access claims the pins whatever the disable bit says
			default: bus_active = eng_busy || start_any || !external_bus_disable_eff_reg;
		endcase
	end

	ext_bus_cycle u_cycle (
		.clk_i        (clk_i),
		.resetn_i     (resetn_i),
		.start_i      (start_any),
		.wait_i       (memory_config_reg[CFG_WAIT_LSB +: 2]),
		.busy_o       (eng_busy),
		.addr_phase_o (eng_addr),
		.data_phase_o (eng_data),
		.sample_o     (eng_sample),
		.done_o       (eng_done)
	);

	// per-access pin plan chosen from the write mode at start
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cur_write_reg  <= 1'b0;
			cur_table_reg  <= 1'b0;
			cur_addr_reg   <= 20'h00000;
			cur_lsb_reg    <= 1'b0;
			cur_data_reg   <= WORD_RESET;
			cur_drive_reg  <= 1'b0;
			cur_wrh_reg    <= 1'b0;
			cur_wrl_reg    <= 1'b0;
			cur_ub_n_reg   <= 1'b0;
			cur_lb_n_reg   <= 1'b0;
			hold_latch_reg <= LATCH_RESET;
		end else if (start_any) begin
			cur_table_reg <= start_tbl;
			cur_write_reg <= start_tbl && tbl_wr_pend_reg;
			cur_addr_reg  <= start_tbl ? table_pointer_reg[20:1] : fetch_addr_i;
			cur_lsb_reg   <= start_tbl && table_pointer_reg[0];
			cur_data_reg  <= {table_latch_reg, table_latch_reg};
			cur_drive_reg <= 1'b0;
			cur_wrh_reg   <= 1'b0;
			cur_wrl_reg   <= 1'b0;
			cur_ub_n_reg  <= 1'b0;
			cur_lb_n_reg  <= 1'b0;
			if (start_tbl && tbl_wr_pend_reg) begin
				cur_drive_reg <= 1'b1;
				if (memory_config_reg[WM_WORD_BIT]) begin
					cur_data_reg <= {table_latch_reg, hold_latch_reg};
					cur_wrh_reg  <= table_pointer_reg[0];
					if (!table_pointer_reg[0]) begin
						hold_latch_reg <= table_latch_reg;
						cur_drive_reg  <= 1'b0;
					end
				end else if (memory_config_reg[1:0] == WM_BYTE_SELECT) begin
					cur_wrh_reg  <= 1'b1;
					cur_ub_n_reg <= !table_pointer_reg[0];
					cur_lb_n_reg <= table_pointer_reg[0];
				end else begin
					cur_wrh_reg <= table_pointer_reg[0];
					cur_wrl_reg <= !table_pointer_reg[0];
				end
			end
		end
	end

	// pins are registered; reset and idle leave every strobe inactive
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ad_o                  <= WORD_RESET;
			ad_oe_o               <= WORD_RESET;
			addr_hi_o             <= 4'h0;
			addr_hi_oe_o          <= 4'h0;
			ale_o                 <= 1'b0;
			oe_n_o                <= 1'b1;
			write_strobe_high_n_o <= 1'b1;
			write_strobe_low_n_o  <= 1'b1;
			byte_addr_lsb_o       <= 1'b0;
			ce_n_o                <= 1'b1;
			lower_byte_enable_n_o <= 1'b1;
			upper_byte_enable_n_o <= 1'b1;
			ctrl_oe_o             <= 1'b0;
			port_mode_o           <= 1'b1;
		end else begin
			ctrl_oe_o   <= bus_active;
			port_mode_o <= !bus_active;
			ale_o       <= bus_active && eng_addr;
			ce_n_o      <= !(bus_active && eng_busy) || sleep_i;
			oe_n_o      <= !(bus_active && eng_data && !cur_write_reg);
			write_strobe_high_n_o <= !(bus_active && eng_data && cur_write_reg && cur_wrh_reg);
			write_strobe_low_n_o  <= !(bus_active && eng_data && cur_write_reg && cur_wrl_reg);
			byte_addr_lsb_o       <= bus_active && eng_busy && cur_lsb_reg;
			upper_byte_enable_n_o <= !(bus_active && eng_busy && !cur_ub_n_reg);
			lower_byte_enable_n_o <= !(bus_active && eng_busy && !cur_lb_n_reg);
			// idle bus floats all twenty address and data lines
			addr_hi_o    <= cur_addr_reg[19:16];
			addr_hi_oe_o <= {4{bus_active && eng_busy}};
			if (bus_active && eng_addr) begin
				ad_o    <= cur_addr_reg[15:0];
				ad_oe_o <= 16'hFFFF;
			end else if (bus_active && eng_data && cur_write_reg && cur_drive_reg) begin
				ad_o    <= cur_data_reg;
				ad_oe_o <= 16'hFFFF;
			end else begin
				ad_o    <= cur_data_reg;
				ad_oe_o <= 16'h0000;
			end
		end
	end

	// bus pins come from outside the clock domain
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ad_sync1_reg <= WORD_RESET;
			ad_sync2_reg <= WORD_RESET;
		end else begin
			ad_sync1_reg <= ad_i;
			ad_sync2_reg <= ad_sync1_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tbl_rdata_reg <= WORD_RESET;
			fetch_data_o  <= WORD_RESET;
			fetch_done_o  <= 1'b0;
		end else begin
			fetch_done_o <= eng_done && !cur_table_reg;
			if (eng_sample && !cur_write_reg) begin
				if (cur_table_reg) begin
					tbl_rdata_reg <= ad_sync2_reg;
				end else begin
					fetch_data_o <= ad_sync2_reg;
				end
			end
		end
	end

endmodule : external_memory_bus_16bit

// file: ext_mem_pkg.sv
// constants, encodings and state types shared by the external memory bus controller
package ext_mem_pkg;

	localparam int unsigned CLK_HZ       = 25000000;
	localparam int unsigned REG_ADDR_W   = 5;

	// register byte offsets
	localparam logic [4:0] CFG_OFFSET    = 5'h00;
	localparam logic [4:0] PTR_OFFSET    = 5'h04;
	localparam logic [4:0] LATCH_OFFSET  = 5'h08;
	localparam logic [4:0] CMD_OFFSET    = 5'h0C;
	localparam logic [4:0] STAT_OFFSET   = 5'h10;

	// memory_config_reg fields
	localparam int unsigned CFG_EXTERNAL_BUS_DISABLE_BIT = 7;
	localparam int unsigned CFG_WAIT_LSB  = 4;
	localparam int unsigned CFG_WM_LSB    = 0;
	localparam int unsigned WM_WORD_BIT   = 1;
	localparam logic [7:0]  CFG_IMPL_MASK = 8'hB3;
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	localparam logic [1:0]  WM_BYTE_WRITE  = 2'b00;
	localparam logic [1:0]  WM_BYTE_SELECT = 2'b01;

	// command and status fields
	localparam int unsigned CMD_WRITE_BIT  = 0;
	localparam int unsigned CMD_READ_BIT   = 1;
	localparam int unsigned STAT_BUSY_BIT  = 0;
	localparam int unsigned STAT_EXT_BIT   = 1;
	localparam int unsigned STAT_EXTERNAL_BUS_DISABLE_BIT = 2;
	localparam int unsigned STAT_PEND_BIT  = 3;
	localparam int unsigned STAT_DATA_LSB  = 16;

	localparam logic [20:0] PTR_RESET   = 21'h000000;
	localparam logic [7:0]  LATCH_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;

	// bus cycle phase lengths in clk_i cycles; data phase covers pin register and sync
	localparam logic [2:0] ADDR_PHASE_CYCLES = 3'h2;
	localparam logic [2:0] DATA_PHASE_BASE   = 3'h4;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		MODE_MICROCONTROLLER = 2'b00,
		MODE_EXTENDED_MC     = 2'b01,
		MODE_BOOT_BLOCK      = 2'b10,
		MODE_MICROPROCESSOR  = 2'b11
	} mem_mode_t;

	typedef enum logic [1:0] {
		CYC_IDLE    = 2'b00,
		CYC_ADDR    = 2'b01,
		CYC_DATA    = 2'b10,
		CYC_RECOVER = 2'b11
	} cycle_state_t;

endpackage : ext_mem_pkg

// file: ext_bus_cycle.sv
// phase sequencer for one external bus cycle: address latch, data, recovery
`timescale 1ns/1ps
module ext_bus_cycle
	import ext_mem_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       start_i,
	input  wire logic [1:0] wait_i,
	output logic            busy_o,
	output logic            addr_phase_o,
	output logic            data_phase_o,
	output logic            sample_o,
	output logic            done_o
);

	cycle_state_t state_reg;
	logic [2:0]   count_reg;
	logic [2:0]   data_len_reg;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_reg    <= CYC_IDLE;
			count_reg    <= 3'h0;
			data_len_reg <= DATA_PHASE_BASE;
		end else begin
			case (state_reg)
				CYC_IDLE: begin
					if (start_i) begin
						state_reg    <= CYC_ADDR;
						count_reg    <= 3'h1;
						// wait field counts down: 11 adds none, 00 adds three
						data_len_reg <= DATA_PHASE_BASE + {1'b0, ~wait_i};
					end
				end
				CYC_ADDR: begin
					if (count_reg == ADDR_PHASE_CYCLES) begin
						state_reg <= CYC_DATA;
						count_reg <= 3'h1;
					end else begin
						count_reg <= count_reg + 3'h1;
					end
				end
				CYC_DATA: begin
					if (count_reg == data_len_reg) begin
						state_reg <= CYC_RECOVER;
					end else begin
						count_reg <= count_reg + 3'h1;
					end
				end
				CYC_RECOVER: begin
					state_reg <= CYC_IDLE;
				end
				default: begin
					state_reg <= CYC_IDLE;
				end
			endcase
		end
	end

	assign busy_o       = (state_reg != CYC_IDLE);
	assign addr_phase_o = (state_reg == CYC_ADDR);
	assign data_phase_o = (state_reg == CYC_DATA);
	assign sample_o     = (state_reg == CYC_DATA) && (count_reg == data_len_reg);
	assign done_o       = (state_reg == CYC_RECOVER);

endmodule : ext_bus_cycle

// file: mem_model.sv
// partner model: word-wide external memory answering bus reads
`timescale 1ns/1ps
module mem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] bus_i,
	input  wire logic        bus_oe_i,
	input  wire logic [3:0]  hi_i,
	input  wire logic        ale_i,
	input  wire logic        oe_n_i,
	input  wire logic        ce_n_i,
	output logic      [15:0] data_o
);
	logic [19:0] addr_reg = 20'h00000;
	logic [15:0] last_reg = 16'h0000;
	logic [15:0] word;
	logic        drive;
	assign word = addr_reg[15:0] ^ 16'h5A3C ^ {addr_reg[19:16], 12'h000};
	assign drive = !ce_n_i && !oe_n_i;
	// a released bus shows the inverse of the last word
	assign data_o = bus_oe_i ? bus_i : (drive ? word : ~last_reg);
	always_ff @(posedge clk_i) begin
		if (ale_i) begin
			addr_reg <= {hi_i, bus_i};
		end
		if (drive) begin
			last_reg <= word;
		end
	end
endmodule : mem_model

// file: external_memory_bus_16bit_props.sv
// assertions on the bus pins and fetch port of the external memory bus controller
`timescale 1ns/1ps
module external_memory_bus_16bit_props (
	input wire logic        clk_i,
	input wire logic        resetn_i,
	input wire logic [1:0]  mem_mode_i,
	input wire logic        exec_external_i,
	input wire logic        sleep_i,
	input wire logic        fetch_valid_i,
	input wire logic        fetch_ready_o,
	input wire logic        fetch_done_o,
	input wire logic [15:0] ad_oe_o,
	input wire logic [3:0]  addr_hi_oe_o,
	input wire logic        ale_o,
	input wire logic        oe_n_o,
	input wire logic        write_strobe_high_n_o,
	input wire logic        write_strobe_low_n_o,
	input wire logic        byte_addr_lsb_o,
	input wire logic        ce_n_o,
	input wire logic        ctrl_oe_o,
	input wire logic        port_mode_o
);
	logic take, wh, wl;
	assign take = fetch_valid_i && fetch_ready_o;
	assign wh = !write_strobe_high_n_o;
	assign wl = !write_strobe_low_n_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=>
		ce_n_o && oe_n_o && !wh && !wl && !ale_o && ad_oe_o == 16'h0000)
		else $error("bus control active after reset");
	a_fetch_phases: assert property (take |-> ##[1:2] (ale_o && ctrl_oe_o)[*2]
		##1 (!ale_o && !oe_n_o && !ce_n_o))
		else $error("latch then output enable order broken");
	a_fetch_time: assert property (take |=> !fetch_done_o[*7] ##[1:4] fetch_done_o)
		else $error("fetch completion out of time");
	a_sleep_ce: assert property (sleep_i && $past(sleep_i) |-> ce_n_o && !fetch_ready_o)
		else $error("chip enable active in sleep");
	a_access_ce: assert property (!oe_n_o || wh || wl |-> !ce_n_o)
		else $error("access without chip enable");
	a_strobe_drive: assert property (wh || wl |-> ad_oe_o == 16'hFFFF && !(wh && wl))
		else $error("write strobe without driven data");
	a_idle_pins: assert property (ce_n_o |-> ad_oe_o == 16'h0000 && addr_hi_oe_o == 4'h0
		&& !ale_o && !byte_addr_lsb_o && oe_n_o && !wh && !wl)
		else $error("idle pin levels wrong");
	a_micro_bus: assert property (mem_mode_i == 2'b11 && $past(mem_mode_i, 2) == 2'b11
		&& $past(resetn_i, 2) |-> ctrl_oe_o && !port_mode_o)
		else $error("bus not held in microprocessor mode");
	a_defer_ports: assert property ($rose(port_mode_o) |-> !$past(exec_external_i))
		else $error("pins released during external execution");
	a_ports_free: assert property (port_mode_o |-> !ctrl_oe_o && ad_oe_o == 16'h0000)
		else $error("bus driven while pins are ports");
endmodule : external_memory_bus_16bit_props
bind external_memory_bus_16bit
	external_memory_bus_16bit_props external_memory_bus_16bit_props_i (.*);

// file: tb_external_memory_bus_16bit.sv
// self-checking bench for the external memory bus controller
`timescale 1ns/1ps
module tb_external_memory_bus_16bit
	import ext_mem_pkg::*;
;
	logic        clk_i, resetn_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
	logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i;
	logic        s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, exec_external_i, sleep_i;
	logic        fetch_valid_i, fetch_ready_o, fetch_done_o, ale_o, oe_n_o, ce_n_o;
	logic        write_strobe_high_n_o, write_strobe_low_n_o, byte_addr_lsb_o;
	logic        lower_byte_enable_n_o, upper_byte_enable_n_o, ctrl_oe_o, port_mode_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, mem_mode_i;
	logic [3:0]  s_axi_wstrb_i, addr_hi_o, addr_hi_oe_o;
	logic [15:0] fetch_data_o, ad_i, ad_o, ad_oe_o;
	logic [19:0] fetch_addr_i;
	logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o, d;
	logic [15:0] rnd = 16'h4117;
	logic [7:0]  held = 8'h00;
	logic        wr_act_q = 1'b0;
	int          n_fail = 0;
	int          n_checks = 0;
	logic [15:0] fq[$];
	logic [20:0] wq[$];
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	wire         wr_act = (write_strobe_high_n_o === 1'b0) || (write_strobe_low_n_o === 1'b0);
	wire  [20:0] wr_pins = {ad_o, write_strobe_high_n_o, write_strobe_low_n_o,
		byte_addr_lsb_o, upper_byte_enable_n_o, lower_byte_enable_n_o};

	external_memory_bus_16bit external_memory_bus_16bit_i (.*);
	mem_model mem_model_i (
		.clk_i    (clk_i),
		.bus_i    (ad_o),
		.bus_oe_i (ad_oe_o[0]),
		.hi_i     (addr_hi_o),
		.ale_i    (ale_o),
		.oe_n_i   (oe_n_o),
		.ce_n_i   (ce_n_o),
		.data_o   (ad_i)
	);

	always #20 clk_i = ~clk_i;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic chk_pin(input string nm, input logic [20:0] e, input logic [20:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pin

	task automatic chk_reg(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic end_sim;
		n_fail += fq.size() + wq.size() + rq.size() + bq.size();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic axi_wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_i);
		bq.push_back(r);
		s_axi_awaddr_i <= {27'h0000000, a};
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_i);
			if (!aw_done && s_axi_awready_o) begin
				aw_done = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!w_done && s_axi_wready_o) begin
				w_done = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge clk_i); while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [4:0] a, input logic c, input logic [33:0] e,
		output logic [31:0] v);
		@(posedge clk_i);
		if (c) begin
			rq.push_back(e);
		end
		s_axi_araddr_i <= {27'h0000000, a};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clk_i); while (!s_axi_rvalid_o);
		v = s_axi_rdata_o;
		s_axi_rready_i <= 1'b0;
	endtask : axi_rd

	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h00000001;
		while (s[STAT_BUSY_BIT] || s[STAT_PEND_BIT]) begin
			axi_rd(STAT_OFFSET, 1'b0, 34'h000000000, s);
		end
	endtask : wait_idle

	task automatic fetch(input logic [19:0] a);
		@(posedge clk_i);
		fq.push_back(a[15:0] ^ 16'h5A3C ^ {a[19:16], 12'h000});
		fetch_addr_i <= a;
		fetch_valid_i <= 1'b1;
		do @(posedge clk_i); while (!fetch_ready_o);
		fetch_valid_i <= 1'b0;
	endtask : fetch

	task automatic tbl_wr(input logic [1:0] m, input logic [20:0] p, input logic [7:0] l);
		logic [20:0] e;
		axi_wr(PTR_OFFSET, {11'h000, p}, RESP_OKAY);
		axi_wr(LATCH_OFFSET, {24'h000000, l}, RESP_OKAY);
		if (m[1]) begin
			e = {l, held, 5'b01100};
		end else if (m[0]) begin
			e = {l, l, 2'b01, p[0], !p[0], p[0]};
		end else begin
			e = {l, l, !p[0], p[0], p[0], 2'b00};
		end
		// an even word write only fills the holding latch
		if (m[1] && !p[0]) begin
			held = l;
		end else begin
			wq.push_back(e);
		end
		axi_wr(CMD_OFFSET, 32'h00000001, RESP_OKAY);
		wait_idle();
	endtask : tbl_wr

	always @(posedge clk_i) begin
		wr_act_q <= wr_act;
		if (fetch_done_o === 1'b1) chk_pin("fetch word", {5'h00, fq.pop_front()}, {5'h00, fetch_data_o});
		if (wr_act && !wr_act_q) chk_pin("write pins", wq.pop_front(), wr_pins);
		if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i) chk_reg("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp_o});
		if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i && rq.size() > 0) chk_reg("rdata", rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
	end

	initial begin
		repeat (8000) @(posedge clk_i);
		n_fail++;
		end_sim();
	end

	initial begin
		{clk_i, resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 5'h00;
		{s_axi_arvalid_i, s_axi_rready_i, exec_external_i, sleep_i, fetch_valid_i} = 5'h00;
		{s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = 96'h0;
		fetch_addr_i = 20'h00000;
		mem_mode_i = 2'b11;
		s_axi_wstrb_i = 4'hF;
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		axi_rd(CFG_OFFSET, 1'b1, {RESP_OKAY, 32'h00000000}, d);
		axi_wr(CFG_OFFSET, 32'h000000FF, RESP_OKAY);
		axi_rd(CFG_OFFSET, 1'b1, {RESP_OKAY, 24'h000000, CFG_IMPL_MASK}, d);
		axi_wr(5'h14, 32'h00000000, RESP_SLVERR);
		axi_rd(5'h14, 1'b1, {RESP_SLVERR, 32'h00000000}, d);
		// wait field 11 first, then 00
		for (int i = 0; i < 9; i++) begin
			if (i == 6) begin
				wait_idle();
				axi_wr(CFG_OFFSET, 32'h00000000, RESP_OKAY);
			end
			rnd = lfsr(rnd);
			fetch({rnd[3:0], rnd});
		end
		wait_idle();
		for (int m = 0; m < 4; m++) begin
			axi_wr(CFG_OFFSET, {24'h000000, 6'h0C, m[1:0]}, RESP_OKAY);
			for (int k = 0; k < 4; k++) begin
				if (!k[0]) rnd = lfsr(rnd);
				tbl_wr(m[1:0], {rnd[4:0], rnd[15:1], k[0]}, k[0] ? rnd[15:8] : rnd[7:0]);
			end
		end
		axi_wr(CMD_OFFSET, 32'h00000002, RESP_OKAY);
		wait_idle();
		d[15:0] = {rnd[0], rnd[15:1]} ^ 16'h5A3C ^ {rnd[4:1], 12'h000};
		axi_rd(STAT_OFFSET, 1'b1, {RESP_OKAY, d[15:0], 16'h0002}, d);
		mem_mode_i <= 2'b01;
		axi_wr(CFG_OFFSET, 32'h000000B0, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		chk_pin("port mode", 21'h000001, {20'h00000, port_mode_o});
		fetch(20'h9ABCD);
		wait_idle();
		axi_wr(CFG_OFFSET, 32'h00000030, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		chk_pin("port mode", 21'h000000, {20'h00000, port_mode_o});
		exec_external_i <= 1'b1;
		axi_wr(CFG_OFFSET, 32'h000000B0, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		chk_pin("port mode", 21'h000000, {20'h00000, port_mode_o});
		exec_external_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk_pin("port mode", 21'h000001, {20'h00000, port_mode_o});
		mem_mode_i <= 2'b11;
		sleep_i <= 1'b1;
		fork
			fetch(20'h5F001);
			begin
				repeat (6) @(posedge clk_i);
				chk_pin("chip enable", 21'h000001, {20'h00000, ce_n_o});
				sleep_i <= 1'b0;
			end
		join
		wait_idle();
		end_sim();
	end
endmodule : tb_external_memory_bus_16bit
